// ---- src/iwd_defines.svh ----
// constants for the indexed-port watchdog: keys, indices, fields, timing
// assumes inclusion by bare name from the modules; the package does not include it
`ifndef IWD_DEFINES_SVH
`define IWD_DEFINES_SVH

`define IWD_PORT_INDEX      1'b0
`define IWD_PORT_DATA       1'b1

`define IWD_KEY_UNLOCK      8'h87
`define IWD_KEY_LOCK        8'haa

`define IWD_REG_FUNC        8'h07
`define IWD_REG_ACT         8'h30
`define IWD_REG_UNIT        8'hf5
`define IWD_REG_CNT         8'hf6
`define IWD_REG_CTL         8'hf7

`define IWD_FUNC_WDT        8'h08
`define IWD_ACT_ON          8'h01

`define IWD_ACT_BIT         0
`define IWD_UNIT_MIN_BIT    3
`define IWD_UNIT_FAST_BIT   4
`define IWD_CTL_MOUSE_BIT   7
`define IWD_CTL_KBD_BIT     6
`define IWD_CTL_FORCE_BIT   5
`define IWD_CTL_STAT_BIT    4

`define IWD_BYTE_RST        8'h00
`define IWD_LOCKED_READ     8'hff

`define IWD_CLK_PERIOD_NS   8
`define IWD_MS_NS           1000000
`define IWD_MS_CYCLES       ((`IWD_MS_NS + `IWD_CLK_PERIOD_NS - 1) / `IWD_CLK_PERIOD_NS)

`define IWD_MS_PER_SEC      16'h03e8
`define IWD_MS_PER_MIN      16'hea60
`define IWD_MS_PER_FSEC     16'h0001
`define IWD_MS_PER_FMIN     16'h003c

`endif

// ---- src/iwd_pkg.sv ----
// types shared by the watchdog modules
// assumes iwd_defines.svh on the include path
package iwd_pkg;
  typedef enum logic [1:0] {
    IWD_LOCKED = 2'b00,
    IWD_KEY1   = 2'b01,
    IWD_OPEN   = 2'b11
  } iwd_cfg_t;
endpackage

// ---- src/iwd_tick_if.sv ----
// link between the watchdog register logic and its unit prescaler
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface iwd_tick_if;
  logic restart;
  logic run;
  logic unit_min;
  logic fast;
  logic tick;
  modport ctl (output restart, output run, output unit_min, output fast, input tick);
  modport pre (input restart, input run, input unit_min, input fast, output tick);
endinterface

// ---- src/iwd_prescaler.sv ----
// unit tick generator: millisecond divider, then ms-per-unit divider
// assumes one clock; restart realigns the unit so the first count is whole
`timescale 1ns/1ps
`include "iwd_defines.svh"
module iwd_prescaler import iwd_pkg::*; #(
  parameter logic [31:0] MS_CYCLES = 32'(`IWD_MS_CYCLES)
) (
  input wire logic core_clk,
  input wire logic rst_b,
  iwd_tick_if.pre  tk
);
  logic [31:0] ms_q;
  logic [31:0] ms_d;
  logic [15:0] unit_q;
  logic [15:0] unit_d;
  logic        tick_q;
  logic        tick_d;
  logic [15:0] lim;

  always_comb begin
    if (tk.fast) begin
      lim = tk.unit_min ? `IWD_MS_PER_FMIN : `IWD_MS_PER_FSEC;
    end else begin
      lim = tk.unit_min ? `IWD_MS_PER_MIN : `IWD_MS_PER_SEC;
    end
    ms_d   = ms_q + 32'd1;
    unit_d = unit_q;
    tick_d = 1'b0;
    if (!tk.run || tk.restart) begin
      ms_d   = 32'd0;
      unit_d = 16'h0000;
    end else if (ms_q == MS_CYCLES - 32'd1) begin
      ms_d   = 32'd0;
      unit_d = unit_q + 16'h0001;
      if (unit_q == lim - 16'h0001) begin
        unit_d = 16'h0000;
        tick_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_q   <= 32'd0;
      unit_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      ms_q   <= ms_d;
      unit_q <= unit_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;
endmodule

// ---- src/iwd_watchdog.sv ----
// watchdog behind an index/data port pair with key-guarded config access
// assumes io strobes come from core_clk logic; activity inputs are async pins
// Contract
// - each data port access goes to the register named by the last index write.
// - config mode opens only after the unlock key is written to the index port twice running.
// - writing the lock key to the index port closes config mode and later data access is ignored.
// - writing the watchdog function number to the function index selects the watchdog registers.
// - the watchdog is disabled after reset and enabled by writing one to the activation register.
// - unit register bit 3 picks seconds when zero (reset) and minutes when one.
// - unit register bit 4 makes each count a thousandth of the chosen unit.
// - a count of zero holds the timer stopped and is the count reset value.
// - a nonzero count sets how many units pass without restart before timeout.
// - every count register write restarts the countdown from the new value.
// - with control bit 6 set, keyboard activity restarts the countdown; clear after reset.
// - writing one to control bit 5 raises timeout at once and the bit reads zero.
// - control bit 4 reads one once the timer has expired.
// - with control bit 7 set, mouse activity restarts the countdown.
`timescale 1ns/1ps
`include "iwd_defines.svh"
module iwd_watchdog import iwd_pkg::*; #(
  parameter logic [31:0] MS_CYCLES = 32'(`IWD_MS_CYCLES)
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic       io_port,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  input  wire logic       kbd_activity,
  input  wire logic       mouse_activity,
  output logic            wdt_timeout
);
  iwd_tick_if tk ();

  iwd_cfg_t   cfg_q;
  iwd_cfg_t   cfg_d;
  logic [7:0] idx_q, idx_d, func_q, func_d, cnt_q, cnt_d, reload_q, reload_d, rdata_q, rdata_d;
  logic       en_q, en_d, min_q, min_d, fast_q, fast_d, kbd_en_q, kbd_en_d;
  logic       mouse_en_q, mouse_en_d, exp_q, exp_d;
  logic [2:0] kbd_s_q, mouse_s_q;
  logic       idx_wr, dat_wr, dat_rd, kbd_rise, mouse_rise, act_restart, cnt_wr, force_wr;
  logic       exp_clr;

  function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] func,
                                   input logic [7:0] target);
    reg_hit = (idx == target) && (func == `IWD_FUNC_WDT);
  endfunction

  assign idx_wr   = io_wr && (io_port == `IWD_PORT_INDEX);
  assign dat_wr   = io_wr && (io_port == `IWD_PORT_DATA) && (cfg_q == IWD_OPEN);
  assign dat_rd   = io_rd && (io_port == `IWD_PORT_DATA) && (cfg_q == IWD_OPEN);
  assign cnt_wr   = dat_wr && reg_hit(idx_q, func_q, `IWD_REG_CNT);
  assign force_wr = dat_wr && reg_hit(idx_q, func_q, `IWD_REG_CTL) &&
                    io_wdata[`IWD_CTL_FORCE_BIT];
  // any cause that may legally drop the expired flag
  assign exp_clr  = cnt_wr || act_restart ||
                    (dat_wr && reg_hit(idx_q, func_q, `IWD_REG_CTL) &&
                     io_wdata[`IWD_CTL_STAT_BIT]);
  // stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
  assign kbd_rise   = kbd_s_q[1] && !kbd_s_q[2];
  assign mouse_rise = mouse_s_q[1] && !mouse_s_q[2];
  assign act_restart = en_q && ((kbd_rise && kbd_en_q) ||
                                (mouse_rise && mouse_en_q));

  always_comb begin
    cfg_d = cfg_q;
    idx_d = idx_q;
    if (idx_wr) begin
      case (cfg_q)
        IWD_LOCKED: cfg_d = (io_wdata == `IWD_KEY_UNLOCK) ? IWD_KEY1 : IWD_LOCKED;
        IWD_KEY1:   cfg_d = (io_wdata == `IWD_KEY_UNLOCK) ? IWD_OPEN : IWD_LOCKED;
        IWD_OPEN: begin
          if (io_wdata == `IWD_KEY_LOCK) begin
            cfg_d = IWD_LOCKED;
          end else begin
            idx_d = io_wdata;
          end
        end
        default:    cfg_d = IWD_LOCKED;
      endcase
    end
  end

  always_comb begin
    func_d     = func_q;
    en_d       = en_q;
    min_d      = min_q;
    fast_d     = fast_q;
    reload_d   = reload_q;
    kbd_en_d   = kbd_en_q;
    mouse_en_d = mouse_en_q;
    if (dat_wr) begin
      if (idx_q == `IWD_REG_FUNC) begin
        func_d = io_wdata;
      end
      if (reg_hit(idx_q, func_q, `IWD_REG_ACT)) begin
        en_d = io_wdata[`IWD_ACT_BIT];
      end
      if (reg_hit(idx_q, func_q, `IWD_REG_UNIT)) begin
        min_d  = io_wdata[`IWD_UNIT_MIN_BIT];
        fast_d = io_wdata[`IWD_UNIT_FAST_BIT];
      end
      if (cnt_wr) begin
        reload_d = io_wdata;
      end
      if (reg_hit(idx_q, func_q, `IWD_REG_CTL)) begin
        kbd_en_d   = io_wdata[`IWD_CTL_KBD_BIT];
        mouse_en_d = io_wdata[`IWD_CTL_MOUSE_BIT];
      end
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (cnt_wr) begin
      cnt_d = io_wdata;
      exp_d = 1'b0;
    end else if (act_restart) begin
      cnt_d = reload_q;
      exp_d = 1'b0;
    end else if (tk.tick && tk.run) begin
      cnt_d = cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        exp_d = 1'b1;
      end
    end
    if (dat_wr && reg_hit(idx_q, func_q, `IWD_REG_CTL) && io_wdata[`IWD_CTL_STAT_BIT]) begin
      exp_d = 1'b0;
    end
    // setting causes are placed last: the force set wins over any clear, expiry only over the status-bit clear
    if (tk.tick && tk.run && (cnt_q == 8'h01) && !cnt_wr && !act_restart) begin
      exp_d = 1'b1;
    end
    if (force_wr) begin
      exp_d = 1'b1;
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (io_rd && (io_port == `IWD_PORT_INDEX)) begin
      rdata_d = (cfg_q == IWD_OPEN) ? idx_q : `IWD_LOCKED_READ;
    end else if (io_rd) begin
      rdata_d = `IWD_LOCKED_READ;
      if (dat_rd) begin
        rdata_d = `IWD_BYTE_RST;
        if (idx_q == `IWD_REG_FUNC) begin
          rdata_d = func_q;
        end else if (reg_hit(idx_q, func_q, `IWD_REG_ACT)) begin
          rdata_d = {7'h00, en_q};
        end else if (reg_hit(idx_q, func_q, `IWD_REG_UNIT)) begin
          rdata_d = {3'h0, fast_q, min_q, 3'h0};
        end else if (reg_hit(idx_q, func_q, `IWD_REG_CNT)) begin
          rdata_d = cnt_q;
        end else if (reg_hit(idx_q, func_q, `IWD_REG_CTL)) begin
          rdata_d = {mouse_en_q, kbd_en_q, 1'b0, exp_q, 4'h0};
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q      <= IWD_LOCKED;
      idx_q      <= `IWD_BYTE_RST;
      func_q     <= `IWD_BYTE_RST;
      en_q       <= 1'b0;
      min_q      <= 1'b0;
      fast_q     <= 1'b0;
      reload_q   <= `IWD_BYTE_RST;
      cnt_q      <= `IWD_BYTE_RST;
      kbd_en_q   <= 1'b0;
      mouse_en_q <= 1'b0;
      exp_q      <= 1'b0;
      rdata_q    <= `IWD_BYTE_RST;
      kbd_s_q    <= 3'h0;
      mouse_s_q  <= 3'h0;
    end else begin
      cfg_q      <= cfg_d;
      idx_q      <= idx_d;
      func_q     <= func_d;
      en_q       <= en_d;
      min_q      <= min_d;
      fast_q     <= fast_d;
      reload_q   <= reload_d;
      cnt_q      <= cnt_d;
      kbd_en_q   <= kbd_en_d;
      mouse_en_q <= mouse_en_d;
      exp_q      <= exp_d;
      rdata_q    <= rdata_d;
      kbd_s_q    <= {kbd_s_q[1:0], kbd_activity};
      mouse_s_q  <= {mouse_s_q[1:0], mouse_activity};
    end
  end

  // zero count or disabled function keeps the prescaler parked
  assign tk.run      = en_q && (cnt_q != 8'h00);
  assign tk.restart  = cnt_wr || act_restart;
  assign tk.unit_min = min_q;
  assign tk.fast     = fast_q;

  iwd_prescaler #(.MS_CYCLES(MS_CYCLES)) u_pre (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tk       (tk)
  );

  assign io_rdata    = rdata_q;
  assign wdt_timeout = exp_q;

  sequence s_unlock_wr;
    idx_wr && (io_wdata == `IWD_KEY_UNLOCK);
  endsequence
  sequence s_opened;
    cfg_q == IWD_OPEN;
  endsequence

  AST_UNLOCK_FIRST: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cfg_q == IWD_LOCKED) and s_unlock_wr |=> (cfg_q == IWD_KEY1))
    else $error("first unlock key did not arm");
  AST_UNLOCK_SECOND: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cfg_q == IWD_KEY1) and s_unlock_wr |=> s_opened)
    else $error("second unlock key did not open");
  AST_LOCK: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_opened and (idx_wr && (io_wdata == `IWD_KEY_LOCK)) |=> (cfg_q == IWD_LOCKED))
    else $error("lock key did not close access");
  AST_LOCKED_IGNORE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cfg_q != IWD_OPEN) && io_wr && io_port |=> $stable(reload_q) && $stable(en_q) &&
    $stable(func_q) && $stable(kbd_en_q))
    else $error("locked data write changed state");
  AST_FUNC_SEL: assert property (@(posedge core_clk) disable iff (!rst_b)
    dat_wr && (idx_q == `IWD_REG_FUNC) |=> (func_q == $past(io_wdata)))
    else $error("function select not stored");
  AST_ENABLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    dat_wr && reg_hit(idx_q, func_q, `IWD_REG_ACT) && (io_wdata == `IWD_ACT_ON) |=> en_q)
    else $error("activation write did not enable");
  AST_RELOAD: assert property (@(posedge core_clk) disable iff (!rst_b)
    cnt_wr |=> (cnt_q == $past(io_wdata)) && !u_pre.tick_q)
    else $error("count write did not restart");
  AST_ZERO_STOP: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cnt_q == 8'h00) && !cnt_wr && !act_restart |=> (cnt_q == 8'h00))
    else $error("zero count moved");
  AST_EXPIRE: assert property (@(posedge core_clk) disable iff (!rst_b)
    tk.tick && tk.run && (cnt_q == 8'h01) && !cnt_wr && !act_restart |=>
    (cnt_q == 8'h00) && wdt_timeout ##1 (wdt_timeout || $past(exp_clr)))
    else $error("expiry did not raise timeout");
  AST_FORCE: assert property (@(posedge core_clk) disable iff (!rst_b)
    force_wr |=> wdt_timeout)
    else $error("forced timeout not raised");
  AST_KBD: assert property (@(posedge core_clk) disable iff (!rst_b)
    en_q && kbd_en_q && kbd_rise && !cnt_wr |=> (cnt_q == $past(reload_q)))
    else $error("keyboard activity did not restart");
  AST_MOUSE: assert property (@(posedge core_clk) disable iff (!rst_b)
    en_q && mouse_en_q && mouse_rise && !cnt_wr |=> (cnt_q == $past(reload_q)))
    else $error("mouse activity did not restart");
  AST_STATUS: assert property (@(posedge core_clk) disable iff (!rst_b)
    dat_rd && reg_hit(idx_q, func_q, `IWD_REG_CTL) |=>
    (io_rdata[`IWD_CTL_STAT_BIT] == $past(exp_q)) && !io_rdata[`IWD_CTL_FORCE_BIT])
    else $error("status readback wrong");
endmodule

// ---- test/iwd_host.sv ----
// host model issuing byte cycles on the index/data port pair
// assumes the device samples strobes on rising core_clk; host moves at falling edges
`timescale 1ns/1ps
`include "iwd_defines.svh"
module iwd_host (
  input  wire logic       core_clk,
  output logic            io_wr,
  output logic            io_rd,
  output logic            io_port,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_port = 1'b0;
    io_wdata = 8'h5a;
  end

  // one strobe cycle; a gap cycle follows so a strobe is never reassigned in one step
  task automatic cyc(input logic wr, input logic port, input logic [7:0] d);
    @(negedge core_clk);
    io_wr = wr;
    io_rd = ~wr;
    io_port = port;
    if (wr) io_wdata = d;
    @(negedge core_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    // released bus must not keep showing the last byte
    io_wdata = ~io_wdata;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    cyc(1'b1, `IWD_PORT_INDEX, idx);
    cyc(1'b1, `IWD_PORT_DATA, d);
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    cyc(1'b1, `IWD_PORT_INDEX, idx);
    cyc(1'b0, `IWD_PORT_DATA, 8'h00);
    d = io_rdata;
  endtask

  task automatic unlock();
    cyc(1'b1, `IWD_PORT_INDEX, `IWD_KEY_UNLOCK);
    cyc(1'b1, `IWD_PORT_INDEX, `IWD_KEY_UNLOCK);
  endtask

  task automatic lock();
    cyc(1'b1, `IWD_PORT_INDEX, `IWD_KEY_LOCK);
  endtask
endmodule

// ---- test/indexed_port_watchdog_timer_tb.sv ----
// self-checking bench for the indexed-port watchdog
// assumes a 4-cycle millisecond so fast modes finish quickly
`timescale 1ns/1ps
`include "iwd_defines.svh"
module indexed_port_watchdog_timer_tb;
  localparam logic [31:0] MS = 32'h0000_0004;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       io_wr;
  logic       io_rd;
  logic       io_port;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       kbd = 1'b0;
  logic       mouse = 1'b0;
  logic       wdt_timeout;
  logic [7:0] v;
  int         bad_count = 0;
  int         total_checks = 0;
  int         seed = 32'h030c;
  int         n;

  always #4 core_clk = ~core_clk;

  iwd_watchdog #(.MS_CYCLES(MS)) u_iwd_watchdog (
    .core_clk(core_clk), .rst_b(rst_b), .io_wr(io_wr), .io_rd(io_rd),
    .io_port(io_port), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .kbd_activity(kbd), .mouse_activity(mouse), .wdt_timeout(wdt_timeout));

  iwd_host u_iwd_host (
    .core_clk(core_clk), .io_wr(io_wr), .io_rd(io_rd), .io_port(io_port),
    .io_wdata(io_wdata), .io_rdata(io_rdata));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rr(input logic [7:0] idx, input logic [7:0] exp);
    u_iwd_host.reg_rd(idx, v);
    chk(v, exp);
  endtask

  // falling edges from the count write until timeout shows: whole units plus the flag register
  function automatic int to_cycles(input int units, input int ms_per_unit);
    return units * ms_per_unit * int'(MS) + 1;
  endfunction

  // timeout must appear between lo and hi falling edges from now
  task automatic wait_to(input int lo, input int hi);
    int c;
    c = 0;
    while (wdt_timeout !== 1'b1 && c <= hi) begin
      @(negedge core_clk);
      c++;
    end
    chk(8'(c >= lo && c <= hi), 8'h01);
    if (c > hi) finish_test();
  endtask

  task automatic quiet(input int cyc);
    repeat (cyc) begin
      @(negedge core_clk);
      chk({7'h00, wdt_timeout}, 8'h00);
    end
  endtask

  initial begin
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    rr(`IWD_REG_CTL, `IWD_LOCKED_READ);
    u_iwd_host.unlock();
    u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h05);
    u_iwd_host.reg_wr(`IWD_REG_FUNC, `IWD_FUNC_WDT);
    rr(`IWD_REG_CNT, 8'h00);
    rr(`IWD_REG_UNIT, 8'h00);
    rr(`IWD_REG_CTL, 8'h00);
    u_iwd_host.reg_wr(`IWD_REG_UNIT, 8'h10);
    u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h02);
    quiet(20);
    u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h00);
    u_iwd_host.reg_wr(`IWD_REG_ACT, `IWD_ACT_ON);
    repeat (4) begin
      n = 1 + ($unsigned($random(seed)) % 8);
      u_iwd_host.reg_wr(`IWD_REG_CNT, 8'(n));
      wait_to(to_cycles(n, 1) - 3, to_cycles(n, 1) + 2);
      rr(`IWD_REG_CTL, 8'h10);
      rr(`IWD_REG_CNT, 8'h00);
    end
    // reload before expiry must push the timeout out
    u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h04);
    quiet(10);
    u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h04);
    quiet(10);
    wait_to(2, 10);
    u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h00);
    quiet(40);
    u_iwd_host.reg_wr(`IWD_REG_CTL, 8'h20);
    wait_to(0, 3);
    rr(`IWD_REG_CTL, 8'h10);
    u_iwd_host.reg_wr(`IWD_REG_CTL, 8'h10);
    chk({7'h00, wdt_timeout}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      u_iwd_host.reg_wr(`IWD_REG_CTL, i ? 8'h40 : 8'h80);
      u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h03);
      repeat (5) begin
        {kbd, mouse} = i ? 2'b10 : 2'b01;
        repeat (3) @(negedge core_clk);
        {kbd, mouse} = 2'b00;
        quiet(5);
      end
      wait_to(3, 14);
    end
    u_iwd_host.reg_wr(`IWD_REG_UNIT, 8'h18);
    rr(`IWD_REG_UNIT, 8'h18);
    u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h01);
    wait_to(to_cycles(1, `IWD_MS_PER_FMIN) - 3, to_cycles(1, `IWD_MS_PER_FMIN) + 2);
    // plain seconds: the only slow unit short enough to run here
    u_iwd_host.reg_wr(`IWD_REG_UNIT, 8'h00);
    rr(`IWD_REG_UNIT, 8'h00);
    u_iwd_host.reg_wr(`IWD_REG_CNT, 8'h01);
    wait_to(to_cycles(1, `IWD_MS_PER_SEC) - 3, to_cycles(1, `IWD_MS_PER_SEC) + 2);
    u_iwd_host.lock();
    rr(`IWD_REG_CNT, `IWD_LOCKED_READ);
    finish_test();
  end
endmodule
